// [hw/serial_link_word_framer.sv]
// Serial link word framer: parallel word assembly, 8B/10B link, word recovery.
// Assumes data_in is synchronous to clk_in; link logic runs on link_clk_in.
`timescale 1ns/1ps
`default_nettype none
`include "framer_consts.svh"

// Operation
// - Bus width select picks 21 or 29 bits
// - Narrow mode ignores inputs 21 to 28
// - Data bits fill the word first
// - One audio bit encodes serial audio inputs
// - One forward control bit per word
// - Final bit is parity over preceding bits
// - Scramble then 8B/10B code each word
// - Receiver samples, decodes, descrambles to bus
// - Data bits keep positions across link
// - Audio off: serial data pin is data
// - Audio pins reserved while audio enabled
// - Control channel runs 100k to 1M
// - Register access mode or raw bypass mode
// - Audio rates 8 to 192 kHz
// - Reverse channel carries control and interrupt
// - Reverse channel independent of forward control
// - Reverse channel unusable for 500 us
// - Link start or stop suspends reverse 350us
// - Device addresses reset to 0x80, 0x90
// - Address register writes change response address
// - Narrow mode drives outputs 21 to 28 low
// - Lock only when aligned, with fewer than four errors in a row
module serial_link_word_framer #(
   parameter int unsigned PWRUP_CYCLES   = `REV_PWRUP_CYC,
   parameter int unsigned SUSPEND_CYCLES = `REV_SUSPEND_CYC
) (
   // Clocks and reset
   input  wire logic                 clk_in,
   input  wire logic                 rstn_in,
   input  wire logic                 link_clk_in,
   // Mode pins
   input  wire logic                 bus_width_select_in,
   input  wire logic                 link_enable_in,
   // Parallel input
   input  wire logic [28:0]          data_in,
   input  wire logic                 data_valid_in,
   output logic                      data_ready_out,
   input  wire logic                 sd_in,
   input  wire logic                 sck_in,
   input  wire logic                 ws_in,
   input  wire logic                 forward_control_in,
   // Parallel output
   output var framer_pkg::par_word_s rx_out,
   output logic                      rx_valid_out,
   output logic                      lock_out,
   // Control channel register access
   input  wire framer_pkg::ctl_req_s ctl_in,
   output logic                      ctl_ack_out,
   output logic [7:0]                ctl_rdata_out,
   // Reverse channel
   input  wire logic                 rev_rx_in,
   input  wire logic                 rev_irq_in,
   output logic                      rev_data_out,
   output logic                      rev_irq_out,
   output logic                      rev_ready_out,
   // Serial link
   output logic                      serial_tx_out,
   input  wire logic                 serial_rx_in
);

   localparam logic [5:0] ENC6 [0:31] = '{
      6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
      6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
      6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
      6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
   localparam logic [3:0] ENC4 [0:7] = '{
      4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
   localparam logic [3:0] ALT7 = 4'h7;
   localparam logic [4:0] D07  = 5'h07;
   localparam logic [2:0] X3   = 3'h3;
   localparam logic [2:0] X7   = 3'h7;

   // 8B/10B encode: returns new disparity and abcdei fghj
   function automatic logic [10:0] enc8b10b(input logic [7:0] b, input logic rd);
      logic [5:0] s6;
      logic [3:0] s4;
      logic       r;
      logic       alt;
      s6 = ENC6[b[4:0]];
      r  = rd;
      if (b[4:0] == D07) begin
         s6 = r ? ~s6 : s6;
      end else if ($countones(s6) != 3) begin
         s6 = r ? ~s6 : s6;
         r  = ~r;
      end
      alt = (!r && (b[4:0] == 5'h11 || b[4:0] == 5'h12 || b[4:0] == 5'h14)) ||
            (r && (b[4:0] == 5'h0B || b[4:0] == 5'h0D || b[4:0] == 5'h0E));
      s4 = (b[7:5] == X7 && alt) ? ALT7 : ENC4[b[7:5]];
      if (b[7:5] == X3) begin
         s4 = r ? ~s4 : s4;
      end else if ($countones(s4) != 2) begin
         s4 = r ? ~s4 : s4;
         r  = ~r;
      end
      return {r, s6, s4};
   endfunction

   // 8B/10B decode by search: returns error flag and byte
   function automatic logic [8:0] dec10b(input logic [9:0] c);
      logic [8:0]  res;
      logic [10:0] e0;
      logic [10:0] e1;
      logic [7:0]  bv;
      res = {1'b1, 8'h00};
      for (int i = 0; i < 256; i++) begin
         bv = 8'(i);
         e0 = enc8b10b(bv, 1'b0);
         e1 = enc8b10b(bv, 1'b1);
         if (e0[9:0] == c || e1[9:0] == c) begin
            res = {1'b0, bv};
         end
      end
      return res;
   endfunction

   // Scrambling mask from the seeded sequence
   function automatic logic [31:0] scr_mask();
      logic [15:0] s;
      logic [31:0] m;
      s = `SCR_SEED;
      m = '0;
      for (int i = 0; i < 32; i++) begin
         m[i] = s[15];
         s    = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
      end
      return m;
   endfunction

   // Word assembly with even parity in bit 0
   function automatic logic [31:0] assemble(input logic [28:0] din, input logic wide,
                                            input logic acb, input logic fcc);
      logic [31:0] w;
      w    = wide ? {din, acb, fcc, 1'b0}
                  : {`WORD_HIGH_ZERO, din[`NARROW_MSB:0], acb, fcc, 1'b0};
      w[0] = ^w;
      return w;
   endfunction

   function automatic logic [7:0] word_byte(input logic [31:0] w, input logic [1:0] idx);
      return w[{~idx, 3'h0} +: 8];
   endfunction

   function automatic logic is_comma(input logic [9:0] c);
      return c == `K28_5 || c == ~`K28_5 || c == `K28_1 || c == ~`K28_1;
   endfunction

   framer_pkg::fast_s q;
   framer_pkg::fast_s d;
   framer_pkg::link_s lq;
   framer_pkg::link_s ld;
   logic              busy;

   // Parallel clock domain
   always_comb begin
      logic        wide;
      logic        aud;
      logic        bypass;
      logic        acb;
      logic        edge_len;
      logic [31:0] w;
      logic [1:0]  slot;
      d        = q;
      wide     = q.bws_sy[1];
      aud      = q.ctrl[`CTRL_AUDIO_EN];
      bypass   = q.ctrl[`CTRL_BYPASS];
      acb      = 1'b0;
      w        = '0;
      slot     = '0;
      edge_len = q.len_sy[1] != q.len_q;
      d.bws_sy  = {q.bws_sy[0], bus_width_select_in};
      d.sd_sy   = {q.sd_sy[0], sd_in};
      d.sck_sy  = {q.sck_sy[0], sck_in};
      d.ws_sy   = {q.ws_sy[0], ws_in};
      d.fcc_sy  = {q.fcc_sy[0], forward_control_in};
      d.len_sy  = {q.len_sy[0], link_enable_in};
      d.rtx_sy  = {q.rtx_sy[0], rev_rx_in};
      d.rirq_sy = {q.rirq_sy[0], rev_irq_in};
      d.ack_sy  = {q.ack_sy[0], lq.ack};
      d.rxt_sy  = {q.rxt_sy[1:0], lq.rx_tog};
      d.lock_sy = {q.lock_sy[0], lq.locked};
      d.len_q   = q.len_sy[1];
      d.since_rst = (&q.since_rst) ? q.since_rst : q.since_rst + 16'h0001;
      // Word assembly and hand-off to the link
      if (data_valid_in && data_ready_out) begin
         if (!aud) begin
            acb = q.sd_sy[1];
         end else begin
            unique case (q.tx_slot)
               2'h0: acb = q.sd_sy[1];
               2'h1: acb = q.sck_sy[1];
               default: acb = q.ws_sy[1];
            endcase
         end
         d.tx_word = assemble(data_in, wide, acb, q.fcc_sy[1]) ^ scr_mask();
         d.tx_k5   = !aud || q.tx_slot == 2'h0;
         d.tx_slot = (!aud || q.tx_slot == `SLOT_LAST) ? 2'h0 : q.tx_slot + 2'h1;
         d.tx_req  = ~q.tx_req;
      end
      // Reverse channel availability, apart from forward control
      if (edge_len && q.rev_cnt < 16'(SUSPEND_CYCLES)) begin
         d.rev_cnt = 16'(SUSPEND_CYCLES);
      end else if (q.rev_cnt != 16'h0000) begin
         d.rev_cnt = q.rev_cnt - 16'h0001;
      end
      d.rev_ready = d.rev_cnt == 16'h0000;
      d.rev_data  = d.rev_ready ? q.rtx_sy[1] : `UART_IDLE;
      d.rev_irq   = d.rev_ready && q.rirq_sy[1];
      // Register access over the control channel
      d.ctl_ack = 1'b0;
      if (ctl_in.valid && !bypass && (ctl_in.dev == q.ser_addr || ctl_in.dev == q.des_addr)) begin
         d.ctl_ack = 1'b1;
         unique case (ctl_in.idx)
            `IDX_SER_ADDR: d.ctl_rdata = q.ser_addr;
            `IDX_DES_ADDR: d.ctl_rdata = q.des_addr;
            `IDX_CTRL:     d.ctl_rdata = q.ctrl;
            `IDX_STATUS:   d.ctl_rdata = {6'h00, q.rev_ready, q.lock};
         endcase
         if (ctl_in.write) begin
            unique case (ctl_in.idx)
               `IDX_SER_ADDR: d.ser_addr = ctl_in.wdata;
               `IDX_DES_ADDR: d.des_addr = ctl_in.wdata;
               `IDX_CTRL:     d.ctrl     = ctl_in.wdata;
               `IDX_STATUS:   d.ctrl     = q.ctrl;
            endcase
         end
      end
      // Received word: descramble, parity, unpack
      d.rx_valid = 1'b0;
      if (q.rxt_sy[2] != q.rxt_sy[1]) begin
         w = lq.rx_word ^ scr_mask();
         d.rx_valid = 1'b1;
         d.par_err  = (^w == 1'b0) ? 4'h0 :
                      ((q.par_err == `ERR_LIMIT) ? q.par_err : q.par_err + 4'h1);
         d.rx_out.data = wide ? w[31:3] : {`WORD_HIGH_ZERO, w[`NARROW_MSB + 3:3]};
         d.rx_out.fcc  = w[1];
         slot = (lq.rx_word_k5 || q.rx_slot == `SLOT_LAST) ? 2'h0 : q.rx_slot + 2'h1;
         d.rx_slot = slot;
         if (!aud) begin
            d.rx_out.sd  = w[2];
            d.rx_out.sck = 1'b0;
            d.rx_out.ws  = 1'b0;
         end else begin
            unique case (slot)
               2'h0: d.rx_out.sd = w[2];
               2'h1: d.rx_out.sck = w[2];
               default: d.rx_out.ws = w[2];
            endcase
         end
      end
      d.lock = q.lock_sy[1] && d.par_err < `ERR_LIMIT;
      if (!rstn_in) begin
         d          = '0;
         d.rev_cnt  = 16'(PWRUP_CYCLES);
         d.rev_data = `UART_IDLE;
         d.ser_addr = `SER_ADDR_RST;
         d.des_addr = `DES_ADDR_RST;
         d.ctrl     = `CTRL_RST;
      end
   end

   always_ff @(posedge clk_in) begin
      q <= d;
   end

   assign busy           = q.tx_req != q.ack_sy[1];
   assign data_ready_out = rstn_in && !busy && q.len_sy[1];
   assign rx_out         = q.rx_out;
   assign rx_valid_out   = q.rx_valid;
   assign lock_out       = q.lock;
   assign ctl_ack_out    = q.ctl_ack;
   assign ctl_rdata_out  = q.ctl_rdata;
   assign rev_data_out   = q.rev_data;
   assign rev_irq_out    = q.rev_irq;
   assign rev_ready_out  = q.rev_ready;

   // Link clock domain
   always_comb begin
      logic [2:0]  ns;
      logic [9:0]  kc;
      logic [10:0] e;
      logic [9:0]  sh;
      logic [8:0]  dc;
      ld    = lq;
      ns    = '0;
      kc    = '0;
      e     = '0;
      dc    = '0;
      sh    = '0;
      ld.rst_sy = {lq.rst_sy[0], rstn_in};
      ld.req_sy = {lq.req_sy[0], q.tx_req};
      ld.len_sy = {lq.len_sy[0], link_enable_in};
      // Transmit: comma then four coded bytes per word
      if (lq.tx_bit == `BIT_LAST) begin
         ns = (lq.tx_sym == `SYM_LAST) ? 3'h0 : lq.tx_sym + 3'h1;
         ld.tx_sym = ns;
         ld.tx_bit = 4'h0;
         if (ns == 3'h0) begin
            ld.cur_valid = lq.pend_full;
            ld.cur       = lq.pend;
            ld.cur_k5    = lq.pend_k5;
            if (lq.pend_full) begin
               ld.pend_full = 1'b0;
               ld.ack       = ~lq.ack;
            end
         end
         if (ns == 3'h0 || !ld.cur_valid) begin
            kc = (ld.cur_k5 || !ld.cur_valid) ? `K28_5 : `K28_1;
            ld.tx_sh = lq.tx_rd ? ~kc : kc;
         end else begin
            e = enc8b10b(word_byte(ld.cur, 2'(ns - 3'h1)), lq.tx_rd);
            ld.tx_sh = e[9:0];
            ld.tx_rd = e[10];
         end
      end else begin
         ld.tx_sh  = {lq.tx_sh[8:0], 1'b0};
         ld.tx_bit = lq.tx_bit + 4'h1;
      end
      ld.tx_out = lq.len_sy[1] && ld.tx_sh[9];
      if (lq.req_sy[1] != lq.req_q) begin
         ld.req_q     = lq.req_sy[1];
         ld.pend      = q.tx_word;
         ld.pend_k5   = q.tx_k5;
         ld.pend_full = 1'b1;
      end
      // Receive: comma search, decode, word collection
      sh = {lq.rx_sh[8:0], serial_rx_in};
      ld.rx_sh = sh;
      if (is_comma(sh)) begin
         ld.aligned = 1'b1;
         ld.rx_bit  = 4'h0;
         ld.rx_sym  = 3'h1;
         ld.rx_k5   = sh == `K28_5 || sh == ~`K28_5;
      end else if (lq.aligned) begin
         if (lq.rx_bit != `BIT_LAST) begin
            ld.rx_bit = lq.rx_bit + 4'h1;
         end else begin
            ld.rx_bit = 4'h0;
            dc = dec10b(sh);
            if (lq.rx_sym == 3'h0) begin
               ld.aligned = 1'b0;
               ld.locked  = 1'b0;
            end else if (dc[8]) begin
               ld.err_cnt = (lq.err_cnt == `ERR_LIMIT) ? lq.err_cnt : lq.err_cnt + 4'h1;
               ld.rx_sym  = 3'h0;
            end else if (lq.rx_sym == `SYM_LAST) begin
               ld.rx_word    = {lq.rx_bytes, dc[7:0]};
               ld.rx_word_k5 = lq.rx_k5;
               ld.rx_tog     = ~lq.rx_tog;
               ld.err_cnt    = 4'h0;
               ld.locked     = 1'b1;
               ld.rx_sym     = 3'h0;
            end else begin
               ld.rx_bytes = {lq.rx_bytes[15:0], dc[7:0]};
               ld.rx_sym   = lq.rx_sym + 3'h1;
            end
         end
      end
      if (ld.err_cnt == `ERR_LIMIT) begin
         ld.locked  = 1'b0;
         ld.aligned = 1'b0;
         ld.err_cnt = 4'h0;
      end
      if (!lq.rst_sy[1]) begin
         ld        = '0;
         ld.rst_sy = {lq.rst_sy[0], rstn_in};
         ld.tx_bit = `BIT_LAST;
         ld.tx_sym = `SYM_LAST;
      end
   end

   always_ff @(posedge link_clk_in) begin
      lq <= ld;
   end

   assign serial_tx_out = lq.tx_out;

   // Checks
   logic [31:0] chk_w;
   assign chk_w = q.tx_word ^ scr_mask();

   sequence s_link_edge;
      q.len_sy[1] != q.len_q;
   endsequence
   sequence s_suspended;
      !q.rev_ready && q.rev_data;
   endsequence

   property p_rev_suspend;
      @(posedge clk_in) disable iff (!rstn_in) s_link_edge |=> s_suspended [*8];
   endproperty
   a_rev_suspend: assert property (p_rev_suspend) else $error("reverse not suspended");

   property p_rev_pwrup;
      @(posedge clk_in) disable iff (!rstn_in) q.rev_ready |-> q.since_rst >= 16'(PWRUP_CYCLES);
   endproperty
   a_rev_pwrup: assert property (p_rev_pwrup) else $error("reverse ready too early");

   property p_addr_reset;
      @(posedge clk_in) $rose(rstn_in) |-> q.ser_addr == `SER_ADDR_RST && q.des_addr == `DES_ADDR_RST;
   endproperty
   a_addr_reset: assert property (p_addr_reset) else $error("address reset value");

   property p_addr_write;
      @(posedge clk_in) disable iff (!rstn_in)
         q.ctl_ack && $past(ctl_in.write) && $past(ctl_in.idx) == `IDX_SER_ADDR
         |-> q.ser_addr == $past(ctl_in.wdata);
   endproperty
   a_addr_write: assert property (p_addr_write) else $error("address not written");

   property p_bypass;
      @(posedge clk_in) disable iff (!rstn_in) ctl_in.valid && q.ctrl[`CTRL_BYPASS] |=> !q.ctl_ack;
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass answered access");

   property p_tx_narrow;
      @(posedge clk_in) disable iff (!rstn_in)
         data_valid_in && data_ready_out && !q.bws_sy[1] |=> chk_w[31:24] == `WORD_HIGH_ZERO;
   endproperty
   a_tx_narrow: assert property (p_tx_narrow) else $error("narrow word high bits");

   property p_tx_parity;
      @(posedge clk_in) disable iff (!rstn_in) $changed(q.tx_req) |-> ^chk_w == 1'b0;
   endproperty
   a_tx_parity: assert property (p_tx_parity) else $error("word parity odd");

   property p_rx_narrow;
      @(posedge clk_in) disable iff (!rstn_in)
         $rose(q.rx_valid) && !q.bws_sy[1] |-> q.rx_out.data[28:21] == `WORD_HIGH_ZERO;
   endproperty
   a_rx_narrow: assert property (p_rx_narrow) else $error("narrow outputs not low");

   property p_lock_align;
      @(posedge link_clk_in) disable iff (!lq.rst_sy[1]) lq.locked |-> lq.aligned;
   endproperty
   a_lock_align: assert property (p_lock_align) else $error("lock without alignment");

   property p_comma_first;
      @(posedge link_clk_in) disable iff (!lq.rst_sy[1])
         lq.tx_bit == 4'h0 && lq.tx_sym == 3'h0 |-> is_comma(lq.tx_sh);
   endproperty
   a_comma_first: assert property (p_comma_first) else $error("word without comma");

endmodule // serial_link_word_framer
`default_nettype wire

// [hw/framer_consts.svh]
// Constants of the serial link word framer.
// Assumes inclusion by bare name; pure definitions, no logic.
`ifndef FRAMER_CONSTS_SVH
`define FRAMER_CONSTS_SVH
`define CLK_PERIOD_NS    20
`define REV_PWRUP_US     500
`define REV_SUSPEND_US   350
`define US_TO_CYC(us)    (((us) * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REV_PWRUP_CYC    `US_TO_CYC(`REV_PWRUP_US)
`define REV_SUSPEND_CYC  `US_TO_CYC(`REV_SUSPEND_US)
`define SER_ADDR_RST     8'h80
`define DES_ADDR_RST     8'h90
`define CTRL_RST         8'h01
`define IDX_SER_ADDR     2'h0
`define IDX_DES_ADDR     2'h1
`define IDX_CTRL         2'h2
`define IDX_STATUS       2'h3
`define CTRL_AUDIO_EN    0
`define CTRL_BYPASS      1
`define NARROW_MSB       20
`define WORD_HIGH_ZERO   8'h00
`define K28_5            10'h0FA
`define K28_1            10'h0F9
`define SYM_LAST         3'h4
`define BIT_LAST         4'h9
`define SCR_SEED         16'hACE1
`define ERR_LIMIT        4'h4
`define SLOT_LAST        2'h2
`define UART_IDLE        1'h1
`endif

// [hw/framer_pkg.sv]
// Types of the serial link word framer.
// Assumes framer_consts.svh holds the numeric constants.
package framer_pkg;
   typedef struct packed {
      logic [28:0] data;
      logic        sd;
      logic        sck;
      logic        ws;
      logic        fcc;
   } par_word_s;

   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] dev;
      logic [1:0] idx;
      logic [7:0] wdata;
   } ctl_req_s;

   typedef struct packed {
      logic [1:0]  bws_sy;
      logic [1:0]  sd_sy;
      logic [1:0]  sck_sy;
      logic [1:0]  ws_sy;
      logic [1:0]  fcc_sy;
      logic [1:0]  len_sy;
      logic        len_q;
      logic [1:0]  rtx_sy;
      logic [1:0]  rirq_sy;
      logic [1:0]  ack_sy;
      logic [2:0]  rxt_sy;
      logic [1:0]  lock_sy;
      logic [15:0] rev_cnt;
      logic        rev_ready;
      logic        rev_data;
      logic        rev_irq;
      logic [7:0]  ser_addr;
      logic [7:0]  des_addr;
      logic [7:0]  ctrl;
      logic        ctl_ack;
      logic [7:0]  ctl_rdata;
      logic        tx_req;
      logic [31:0] tx_word;
      logic        tx_k5;
      logic [1:0]  tx_slot;
      logic [1:0]  rx_slot;
      par_word_s   rx_out;
      logic        rx_valid;
      logic [3:0]  par_err;
      logic        lock;
      logic [15:0] since_rst;
   } fast_s;

   typedef struct packed {
      logic [1:0]  rst_sy;
      logic [1:0]  req_sy;
      logic        req_q;
      logic [1:0]  len_sy;
      logic [31:0] pend;
      logic        pend_k5;
      logic        pend_full;
      logic        ack;
      logic [31:0] cur;
      logic        cur_k5;
      logic        cur_valid;
      logic [9:0]  tx_sh;
      logic [3:0]  tx_bit;
      logic [2:0]  tx_sym;
      logic        tx_rd;
      logic        tx_out;
      logic [9:0]  rx_sh;
      logic [3:0]  rx_bit;
      logic [2:0]  rx_sym;
      logic        aligned;
      logic [23:0] rx_bytes;
      logic        rx_k5;
      logic [31:0] rx_word;
      logic        rx_word_k5;
      logic        rx_tog;
      logic [3:0]  err_cnt;
      logic        locked;
   } link_s;
endpackage

// [bench/far_side_model.sv]
// Far side of the serial link: a paired receiver that returns the stream.
// Assumes the bench sets the reverse data and interrupt levels.
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
   // Link side
   input  wire logic link_clk_in,
   input  wire logic tx_in,
   output logic      rx_out,
   // Reverse channel levels
   input  wire logic rev_in,
   input  wire logic irq_in,
   output logic      rev_out,
   output logic      irq_out
);
   // Frame comes back whole, one bit late
   always_ff @(posedge link_clk_in) begin
      rx_out <= tx_in;
   end
   // Reverse levels run regardless of forward traffic
   assign rev_out = rev_in;
   assign irq_out = irq_in;
endmodule  // far_side_model
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench of the serial link word framer.
// Assumes the far side model loops the serial stream back.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic                  clk_in = 0, lclk = 0, rstn_in = 0, bus_width_select = 0, len = 0, dv = 0;
   logic                  sd = 0, sck = 0, ws = 0, fcc = 0, rrx = 1, rirq = 0, tx, prx, prev, pirq;
   logic                  rdo, rio, rdy, rxv, lock, ack, rrdy, a;
   logic [28:0]           din = '0, expd;
   logic [7:0]            rdat, rd;
   framer_pkg::ctl_req_s  ctl = '0;
   framer_pkg::par_word_s rxo;
   int                    n_fail = 0, checks_done = 0, n, i, aslot = 0;
   always #10 clk_in = ~clk_in;
   initial #7 forever #62.5 lclk = ~lclk;
   serial_link_word_framer #(.PWRUP_CYCLES(40), .SUSPEND_CYCLES(20)) u_serial_link_word_framer (
      .clk_in(clk_in), .rstn_in(rstn_in), .link_clk_in(lclk), .bus_width_select_in(bus_width_select),
      .link_enable_in(len), .data_in(din), .data_valid_in(dv), .data_ready_out(rdy),
      .sd_in(sd), .sck_in(sck), .ws_in(ws), .forward_control_in(fcc), .rx_out(rxo),
      .rx_valid_out(rxv), .lock_out(lock), .ctl_in(ctl), .ctl_ack_out(ack),
      .ctl_rdata_out(rdat), .rev_rx_in(prev), .rev_irq_in(pirq), .rev_data_out(rdo),
      .rev_irq_out(rio), .rev_ready_out(rrdy), .serial_tx_out(tx), .serial_rx_in(prx));
   far_side_model u_far_side_model (.link_clk_in(lclk), .tx_in(tx), .rx_out(prx),
      .rev_in(rrx), .irq_in(rirq), .rev_out(prev), .irq_out(pirq));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %0t %s", $time, msg);
      end
   endtask
   task automatic test_done();
      $display("Counts: %0d checks, %0d mismatches", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Bounded wait: 0 ready, 1 received word, 2 reverse ready
   task automatic wt(input int which, input int lim, output int k);
      for (k = 0; k < lim; k++) begin
         @(negedge clk_in);
         if ((which == 0 && rdy === 1'b1) || (which == 2 && rrdy === 1'b1) ||
             (which == 1 && rxv === 1'b1)) break;
      end
      if (k == lim) begin
         n_fail++;
         $display("MISMATCH %0t wait expired", $time);
         test_done();
      end
   endtask
   task automatic ctl_op(input logic w, input logic [7:0] dev, input logic [1:0] idx,
                         input logic [7:0] wd, output logic got, output logic [7:0] val);
      ctl = '{1'b1, w, dev, idx, wd};
      @(negedge clk_in);
      ctl.valid = 1'b0;
      got = ack;
      @(negedge clk_in);
      got = got | ack;
      val = rdat;
   endtask
   function automatic logic [28:0] exp_word(input logic [28:0] d, input logic w);
      return w ? d : {8'h00, d[20:0]};
   endfunction
   task automatic send(input logic [28:0] d, input logic w, input logic aoff);
      int k;
      logic got;
      bus_width_select = w;
      fcc = d[3];
      sd = d[5];
      sck = d[6];
      ws = d[7];
      expd = exp_word(d, w);
      repeat (6) @(negedge clk_in);
      wt(0, 2000, k);
      din = d;
      dv = 1'b1;
      @(negedge clk_in);
      dv = 1'b0;
      din = ~d;
      wt(1, 3000, k);
      chk(rxo.data, expd, "word data");
      chk(rxo.fcc, d[3], "control bit");
      chk(lock, 1'b1, "lock");
      if (aoff) begin
         chk(rxo.sd, d[5], "sd as data");
         chk({rxo.sck, rxo.ws}, 2'b00, "audio idle");
         aslot = 0;
      end else begin
         got = (aslot == 0) ? rxo.sd : (aslot == 1) ? rxo.sck : rxo.ws;
         chk(got, d[5 + aslot], "audio bit");
         aslot = (aslot + 1) % 3;
      end
   endtask
   initial begin
      n = $urandom(16593);
      repeat (12) @(negedge clk_in);
      rstn_in = 1'b1;
      wt(2, 200, n);
      chk(n >= 38 && n <= 44, 1'b1, "power-up hold");
      chk(lock, 1'b0, "early lock");
      ctl_op(0, 8'h80, 2'h0, 8'h00, a, rd);
      chk({a, rd}, 9'h180, "ser addr reset");
      ctl_op(0, 8'h90, 2'h1, 8'h00, a, rd);
      chk({a, rd}, 9'h190, "des addr reset");
      $display("reset values done");
      len = 1'b1;
      repeat (3) @(negedge clk_in);
      wt(2, 200, n);
      chk(n >= 14 && n <= 22, 1'b1, "start suspend");
      rrx = 1'b0;
      rirq = 1'b1;
      fcc = 1'b1;
      repeat (5) @(negedge clk_in);
      chk({rdo, rio}, 2'b01, "reverse levels");
      $display("reverse channel done");
      send('1, 1'b0, 1'b0);
      send('1, 1'b1, 1'b0);
      for (i = 0; i < 6; i++) send(29'($urandom), i[0], 1'b0);
      ctl_op(1, 8'h90, 2'h2, 8'h00, a, rd);
      send(29'($urandom) | 29'h20, 1'b1, 1'b1);
      send(29'($urandom) & ~29'h20, 1'b0, 1'b1);
      $display("data words done");
      ctl_op(1, 8'h80, 2'h0, 8'h42, a, rd);
      chk({a, rd}, 9'h180, "old value on write");
      ctl_op(0, 8'h80, 2'h0, 8'h00, a, rd);
      chk(a, 1'b0, "old address refused");
      ctl_op(0, 8'h42, 2'h0, 8'h00, a, rd);
      chk({a, rd}, 9'h142, "new address");
      ctl_op(1, 8'h42, 2'h2, 8'h02, a, rd);
      ctl_op(0, 8'h42, 2'h2, 8'h00, a, rd);
      chk(a, 1'b0, "bypass refuses access");
      $display("address change done");
      len = 1'b0;
      repeat (3) @(negedge clk_in);
      wt(2, 200, n);
      chk(n >= 14 && n <= 22, 1'b1, "stop suspend");
      chk(tx, 1'b0, "link stopped quiet");
      $display("link stop done");
      test_done();
   end
endmodule  // testbench
`default_nettype wire
